// ===== hdl/nvm_config.sv
// Our own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
module nvm_config
  import nvm_config_pkg::*;
#(
  parameter int KEY_LEN   = nvm_config_pkg::KEY_BYTES,
  parameter int OP_WIDTH  = nvm_config_pkg::OP_COUNT_WIDTH
) (
  // clock, reset, enable
  input  wire logic                             hclk,
  input  wire logic                             hresetn,
  input  wire logic                             ce,
  // ahb-lite slave
  input  wire logic                             hsel,
  input  wire logic [31:0]                      haddr,
  input  wire logic [1:0]                       htrans,
  input  wire logic                             hwrite,
  input  wire logic [2:0]                       hsize,
  input  wire logic [31:0]                      hwdata,
  input  wire logic                             hready,
  output logic                                  hreadyout,
  output logic                                  hresp,
  output logic [31:0]                           hrdata,
  // source of the current bus master
  input  wire logic                             bus_src_secure,
  input  wire logic                             bus_src_debug,
  // nonvolatile contents
  input  wire logic [7:0]                       stored_option_byte,
  input  wire logic [8*KEY_LEN-1:0]             stored_unlock_key,
  input  wire logic                             blank_check_pass,
  // erase and program control
  input  wire nvm_config_pkg::op_req_type       op_req,
  output nvm_config_pkg::op_resp_type           op_resp,
  output logic                                  nvm_timing_tick,
  // memory access gate
  input  wire nvm_config_pkg::mem_req_type      mem_req,
  output nvm_config_pkg::mem_resp_type          mem_resp,
  // option outputs
  output logic [7:0]                            option_mirror,
  output logic                                  unsecured,
  output logic                                  vector_redirect_enable,
  output logic                                  eeprom_eight_byte_mode
);

  if (KEY_LEN != KEY_BYTES || OP_WIDTH < 1) begin : g_check
    $error("unsupported key length or operation counter width");
  end

  localparam int KIW = $clog2(KEY_LEN + 1);

  typedef struct packed {
    logic                option_loaded;
    logic [7:0]          option;
    logic [7:0]          ratio;
    logic                dp_valid;
    logic                dp_write;
    logic [7:0]          dp_addr;
    logic                dp_secure;
    logic                dp_debug;
    logic [31:0]         rdata;
    logic                key_access;
    logic [KIW-1:0]      key_index;
    logic                key_match;
    logic [OP_WIDTH-1:0] op_remaining;
    op_resp_type         op;
    mem_resp_type        mem;
    logic                unsecured;
    logic                redirect_enable;
    logic                eight_byte;
  } cfg_state_type;

  cfg_state_type s;
  cfg_state_type next_s;
  logic          timing_tick;

  // timing clock divider, held idle until the ratio is loaded
  nvm_timing_divider #(
    .RATIO_WIDTH (RATIO_WIDTH),
    .PRESCALE    (PRESCALE_DIV)
  ) u_divider (
    .hclk              (hclk),
    .hresetn           (hresetn),
    .ce                (ce),
    .run               (s.ratio[RATIO_LOADED_BIT]),
    .prescale_by_eight (s.ratio[PRESCALE_BIT]),
    .clock_ratio_field (s.ratio[RATIO_WIDTH-1:0]),
    .timing_tick       (timing_tick)
  );

  // all next-state logic: bus writes first, then read data from the result
  always_comb begin
    logic       lock_open;
    logic       allowed;
    logic [7:0] key_byte;
    logic [7:0] wbyte;
    lock_open = 1'b0;
    allowed = 1'b0;
    key_byte = 8'h00;
    wbyte = hwdata[7:0];
    next_s = s;
    next_s.op.accepted = 1'b0;
    next_s.op.refused = 1'b0;
    next_s.op.done = 1'b0;
    next_s.mem.write_enable = 1'b0;
    next_s.mem.blocked = 1'b0;

    // first enabled edge after reset release copies the stored byte
    if (!s.option_loaded) begin
      next_s.option_loaded = 1'b1;
      next_s.option = stored_option_byte;
    end

    // data phase of a write
    if (s.dp_valid && s.dp_write) begin
      unique case (s.dp_addr)
        ADDR_CLOCK_RATIO: begin
          if (!s.ratio[RATIO_LOADED_BIT]) begin
            next_s.ratio = wbyte & RATIO_WRITE_MASK;
            next_s.ratio[RATIO_LOADED_BIT] = 1'b1;
          end
        end
        ADDR_KEY_CTRL: begin
          next_s.key_access = wbyte[KEY_ACCESS_BIT];
          if (wbyte[KEY_ACCESS_BIT] && !s.key_access) begin
            next_s.key_index = '0;
            next_s.key_match = 1'b1;
          end
          if (!wbyte[KEY_ACCESS_BIT] && s.key_access && s.option[BACKDOOR_BIT]
              && s.key_match && s.key_index == KIW'(KEY_LEN)) begin
            next_s.option[1:0] = LOCK_UNSECURED;
          end
        end
        ADDR_KEY_DATA: begin
          if (s.key_access && s.dp_secure && !s.dp_debug) begin
            if (s.key_index < KIW'(KEY_LEN)) begin
              key_byte = stored_unlock_key[8*s.key_index +: 8];
              next_s.key_match = s.key_match && (wbyte == key_byte);
              next_s.key_index = KIW'(s.key_index + 1'b1);
            end else begin
              next_s.key_match = 1'b0;
            end
          end
        end
        default: begin
          // option mirror, status and unmapped words ignore writes
        end
      endcase
    end

    // blank check of the whole array opens the part
    if (blank_check_pass && s.option_loaded) begin
      next_s.option[1:0] = LOCK_UNSECURED;
    end
    lock_open = (next_s.option[1:0] == LOCK_UNSECURED);
    next_s.unsecured = lock_open;
    next_s.redirect_enable = !next_s.option[REDIRECT_BIT];
    next_s.eight_byte = next_s.option[LAYOUT_BIT];

    // erase and program operations counted in timing pulses
    if (s.op.busy && timing_tick) begin
      if (s.op_remaining <= OP_WIDTH'(1)) begin
        next_s.op_remaining = '0;
        next_s.op.busy = 1'b0;
        next_s.op.done = 1'b1;
      end else begin
        next_s.op_remaining = OP_WIDTH'(s.op_remaining - 1'b1);
      end
    end
    if (op_req.request) begin
      if (!s.ratio[RATIO_LOADED_BIT] || s.op.busy) begin
        next_s.op.refused = 1'b1;
      end else begin
        next_s.op.accepted = 1'b1;
        next_s.op.busy = 1'b1;
        next_s.op_remaining = (op_req.pulses == '0) ? OP_WIDTH'(1) : op_req.pulses;
      end
    end

    // memory gate toward ram, eeprom and flash
    if (mem_req.valid) begin
      allowed = s.unsecured || (mem_req.src_secure && !mem_req.src_debug);
      next_s.mem.blocked = !allowed;
      next_s.mem.write_enable = mem_req.write && allowed;
      if (!mem_req.write) begin
        next_s.mem.rdata = allowed ? mem_req.array_rdata : 8'h00;
      end
    end

    // address phase capture and registered read data
    next_s.dp_valid = 1'b0;
    if (hsel && hready && htrans == HTRANS_NONSEQ) begin
      next_s.dp_valid = 1'b1;
      next_s.dp_write = hwrite;
      next_s.dp_addr = haddr[7:0];
      next_s.dp_secure = bus_src_secure;
      next_s.dp_debug = bus_src_debug;
      next_s.rdata = 32'h0000_0000;
      if (!hwrite) begin
        unique case (haddr[7:0])
          ADDR_CLOCK_RATIO: next_s.rdata[7:0] = next_s.ratio;
          ADDR_OPTION:      next_s.rdata[7:0] = next_s.option;
          ADDR_KEY_CTRL:    next_s.rdata[KEY_ACCESS_BIT] = next_s.key_access;
          ADDR_STATUS: begin
            next_s.rdata[STAT_UNSECURED] = next_s.unsecured;
            next_s.rdata[STAT_OPS_ENABLED] = next_s.ratio[RATIO_LOADED_BIT];
            next_s.rdata[STAT_BUSY] = next_s.op.busy;
            next_s.rdata[STAT_KEY_INDEX +: KIW] = next_s.key_index;
          end
          default: next_s.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // single state register, frozen while ce is low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.option <= OPTION_RESET;
      s.ratio <= RATIO_RESET;
      s.key_match <= 1'b1;
      s.eight_byte <= OPTION_RESET[LAYOUT_BIT]; // derived outputs agree with the reset mirror
    end else if (ce) begin
      s <= next_s;
    end
  end

  // outputs straight from the state registers, with hreadyout and hresp tied off
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign hrdata = s.rdata;
  assign op_resp = s.op;
  assign nvm_timing_tick = timing_tick;
  assign mem_resp = s.mem;
  assign option_mirror = s.option;
  assign unsecured = s.unsecured;
  assign vector_redirect_enable = s.redirect_enable;
  assign eeprom_eight_byte_mode = s.eight_byte;

endmodule

// ===== hdl/nvm_config_pkg.sv
package nvm_config_pkg;

  // clocking and timing-clock window
  localparam int          BUS_CLOCK_HZ      = 25000000;
  localparam int          NVM_TIMING_CLOCK_MIN_HZ       = 150000;
  localparam int          NVM_TIMING_CLOCK_MAX_HZ       = 200000;
  localparam int          PRESCALE_DIV      = 8;
  localparam int          RATIO_WIDTH       = 6;
  localparam int          KEY_BYTES         = 8;
  localparam int          OP_COUNT_WIDTH    = 16;

  // register byte offsets (decoded on haddr[7:0])
  localparam logic [7:0]  ADDR_CLOCK_RATIO  = 8'h00;
  localparam logic [7:0]  ADDR_OPTION       = 8'h04;
  localparam logic [7:0]  ADDR_KEY_CTRL     = 8'h08;
  localparam logic [7:0]  ADDR_KEY_DATA     = 8'h0c;
  localparam logic [7:0]  ADDR_STATUS       = 8'h10;

  // clock ratio register fields
  localparam int          RATIO_LOADED_BIT  = 7;
  localparam int          PRESCALE_BIT      = 6;
  localparam logic [7:0]  RATIO_RESET       = 8'h00;
  localparam logic [7:0]  RATIO_WRITE_MASK  = 8'h7f;

  // option mirror fields
  localparam int          BACKDOOR_BIT      = 7;
  localparam int          REDIRECT_BIT      = 6;
  localparam int          LAYOUT_BIT        = 5;
  localparam logic [7:0]  OPTION_RESET      = 8'hff;
  localparam logic [1:0]  LOCK_UNSECURED    = 2'h2;

  // key control and status fields
  localparam int          KEY_ACCESS_BIT    = 0;
  localparam int          STAT_UNSECURED    = 0;
  localparam int          STAT_OPS_ENABLED  = 1;
  localparam int          STAT_BUSY         = 2;
  localparam int          STAT_KEY_INDEX    = 4;

  // ahb-lite encodings
  localparam logic [1:0]  HTRANS_NONSEQ     = 2'h2;
  localparam logic        HRESP_OKAY        = 1'h0;

  // memory access request from an instruction source
  typedef struct packed {
    logic       valid;
    logic       write;
    logic       src_secure;
    logic       src_debug;
    logic [7:0] array_rdata;
  } mem_req_type;

  // gated answer toward the requester and the array
  typedef struct packed {
    logic       write_enable;
    logic       blocked;
    logic [7:0] rdata;
  } mem_resp_type;

  // erase or program request from the command logic
  typedef struct packed {
    logic                      request;
    logic [OP_COUNT_WIDTH-1:0] pulses;
  } op_req_type;

  // erase or program status back to the command logic
  typedef struct packed {
    logic accepted;
    logic refused;
    logic busy;
    logic done;
  } op_resp_type;

endpackage

// ===== hdl/nvm_timing_divider.sv
`timescale 1ns/1ps
module nvm_timing_divider #(
  parameter int RATIO_WIDTH = 6,
  parameter int PRESCALE    = 8
) (
  // clock and reset
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   ce,
  // divider setting
  input  wire logic                   run,
  input  wire logic                   prescale_by_eight,
  input  wire logic [RATIO_WIDTH-1:0] clock_ratio_field,
  // one bus cycle per timing clock period
  output logic                        timing_tick
);

  localparam int PW = $clog2(PRESCALE);

  typedef struct packed {
    logic [PW-1:0]          pre_count;
    logic [RATIO_WIDTH-1:0] ratio_count;
    logic                   tick;
  } div_state_type;

  div_state_type s;
  div_state_type next_s;

  if (PRESCALE < 2 || (1 << PW) != PRESCALE) begin : g_check
    $error("prescale must be a power of two");
  end

  // prescaler stage then ratio counter, counting ratio plus one stages
  always_comb begin
    logic stage;
    stage = 1'b0;
    next_s = s;
    next_s.tick = 1'b0;
    if (run) begin
      stage = !prescale_by_eight || (s.pre_count == PW'(PRESCALE - 1));
      if (prescale_by_eight) begin
        next_s.pre_count = PW'(s.pre_count + 1'b1);
      end
      if (stage) begin
        if (s.ratio_count == clock_ratio_field) begin
          next_s.ratio_count = '0;
          next_s.tick = 1'b1;
        end else begin
          next_s.ratio_count = RATIO_WIDTH'(s.ratio_count + 1'b1);
        end
      end
    end else begin
      next_s.pre_count = '0;
      next_s.ratio_count = '0;
    end
  end

  // state register, frozen while ce is low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign timing_tick = s.tick;

endmodule

// ===== test/nvm_config_assertions.sv
`timescale 1ns/1ps
module nvm_config_assertions
  import nvm_config_pkg::*;
(
  // bus side
  input wire logic                         hclk,
  input wire logic                         hresetn,
  input wire logic                         hsel,
  input wire logic [31:0]                  haddr,
  input wire logic [1:0]                   htrans,
  input wire logic                         hwrite,
  input wire logic                         hready,
  // operations and memory gate
  input wire nvm_config_pkg::op_req_type   op_req,
  input wire nvm_config_pkg::op_resp_type  op_resp,
  input wire nvm_config_pkg::mem_req_type  mem_req,
  input wire nvm_config_pkg::mem_resp_type mem_resp,
  input wire logic                         nvm_timing_tick,
  // options
  input wire logic [7:0]                   option_mirror,
  input wire logic                         unsecured,
  input wire logic                         vector_redirect_enable,
  input wire logic                         eeprom_eight_byte_mode
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic wr_pend;
  logic loaded;
  // track the first ratio register write at its data edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      loaded  <= 1'b0;
    end else begin
      wr_pend <= hsel && hready && htrans == HTRANS_NONSEQ && hwrite
                 && haddr[7:0] == ADDR_CLOCK_RATIO;
      if (wr_pend) loaded <= 1'b1;
    end
  end
  sequence s_foreign;
    mem_req.valid && (mem_req.src_debug || !mem_req.src_secure) && !unsecured
      && option_mirror[1:0] != LOCK_UNSECURED;
  endsequence
  sequence s_trusted;
    mem_req.valid && mem_req.src_secure && !mem_req.src_debug;
  endsequence
  a_refuse_unloaded: assert property (op_req.request && !loaded |=> op_resp.refused)
    else $error("request accepted before ratio load");
  a_accept_loaded: assert property (loaded && op_req.request && !op_resp.busy |=> op_resp.accepted)
    else $error("request not accepted after ratio load");
  a_tick_loaded: assert property (!loaded |-> !nvm_timing_tick)
    else $error("timing tick before ratio load");
  a_busy_done: assert property ($fell(op_resp.busy) |-> op_resp.done)
    else $error("busy ended without done");
  a_blocked_zero: assert property (mem_resp.blocked |-> !mem_resp.write_enable && ($past(mem_req.write) || mem_resp.rdata == 8'h00))
    else $error("blocked access leaked data");
  a_foreign_block: assert property (s_foreign |=> mem_resp.blocked)
    else $error("foreign access not blocked");
  a_trusted_pass: assert property (s_trusted |=> !mem_resp.blocked && mem_resp.write_enable == $past(mem_req.write))
    else $error("secure access wrongly gated");
  a_lock_code: assert property (unsecured == (option_mirror[1:0] == LOCK_UNSECURED))
    else $error("unsecured disagrees with lock code");
  a_redirect_bit: assert property (vector_redirect_enable == !option_mirror[REDIRECT_BIT])
    else $error("redirect enable wrong");
  a_layout_bit: assert property (eeprom_eight_byte_mode == option_mirror[LAYOUT_BIT])
    else $error("sector layout wrong");
endmodule
bind nvm_config nvm_config_assertions chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hready, .op_req, .op_resp, .mem_req, .mem_resp, .nvm_timing_tick, .option_mirror, .unsecured,
  .vector_redirect_enable, .eeprom_eight_byte_mode);

// ===== test/tb_nvm_config.sv
`timescale 1ns/1ps
module tb_nvm_config;
  import nvm_config_pkg::*;
  localparam logic [63:0] KEY = 64'h8877665544332211;
  logic         hclk = 1'b0;
  logic         hresetn = 1'b0;
  logic [31:0]  haddr = 32'h0;
  logic [1:0]   htrans = 2'h0;
  logic         hwrite = 1'b0;
  logic [31:0]  hwdata = 32'h0;
  logic         hreadyout;
  logic         hresp;
  logic [31:0]  hrdata;
  logic         sec = 1'b1;
  logic         dbg = 1'b0;
  logic [7:0]   opt = 8'h83;
  logic         blank = 1'b0;
  op_req_type   op_req = '0;
  op_resp_type  op_resp;
  mem_req_type  mem_req = '0;
  mem_resp_type mem_resp;
  mem_resp_type mr;
  logic         tick;
  logic [7:0]   omir;
  logic         unsec;
  logic         redir;
  logic         eight;
  logic [31:0]  rd;
  int           errors = 0;
  int           n_tests = 0;
  int           cyc = 0;
  nvm_config dut_u (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(1'b1),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .bus_src_secure(sec),
    .bus_src_debug(dbg), .stored_option_byte(opt), .stored_unlock_key(KEY),
    .blank_check_pass(blank), .op_req(op_req), .op_resp(op_resp), .nvm_timing_tick(tick),
    .mem_req(mem_req), .mem_resp(mem_resp), .option_mirror(omir), .unsecured(unsec),
    .vector_redirect_enable(redir), .eeprom_eight_byte_mode(eight));
  // bus clock
  always #20 hclk = ~hclk;
  // hang guard
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      errors++;
      test_done;
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("errors=%0d comparisons=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // one single ahb-lite transfer, read data left in rd
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task do_reset(input logic [7:0] o);
    opt <= o;
    hresetn <= 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
  endtask
  task mem(input logic w, input logic s, input logic d);
    mem_req <= '{1'b1, w, s, d, 8'h5a};
    @(posedge hclk);
    mem_req.valid <= 1'b0;
    @(negedge hclk);
    mr = mem_resp;
    @(posedge hclk);
  endtask
  task t_options;
    bus(1'b0, ADDR_OPTION, 8'h00);
    chk(rd, {24'h0, opt});
    bus(1'b1, ADDR_OPTION, ~opt);
    bus(1'b0, ADDR_OPTION, 8'h00);
    chk(rd, {24'h0, opt});
    chk(32'(redir), 32'(!opt[6]));
    chk(32'(eight), 32'(opt[5]));
    chk(32'(unsec), 32'(opt[1:0] == LOCK_UNSECURED));
  endtask
  task t_ratio(input logic [7:0] w, input int period);
    int c;
    bus(1'b0, ADDR_CLOCK_RATIO, 8'h00);
    chk(rd, 32'h0);
    op_req <= '{1'b1, 16'h0001};
    @(posedge hclk);
    op_req.request <= 1'b0;
    @(negedge hclk);
    chk(32'(op_resp.refused), 32'h1);
    @(posedge hclk);
    bus(1'b1, ADDR_CLOCK_RATIO, w);
    bus(1'b0, ADDR_CLOCK_RATIO, 8'h00);
    chk(rd, {24'h0, 1'b1, w[6:0]});
    bus(1'b1, ADDR_CLOCK_RATIO, ~w);
    bus(1'b0, ADDR_CLOCK_RATIO, 8'h00);
    chk(rd, {24'h0, 1'b1, w[6:0]});
    do @(negedge hclk); while (tick !== 1'b1);
    c = 0;
    do begin
      @(negedge hclk);
      c++;
    end while (tick !== 1'b1 && c < 1000);
    chk(c, period);
    @(posedge hclk);
  endtask
  task t_op;
    int n;
    n = 0;
    op_req <= '{1'b1, 16'h0003};
    @(posedge hclk);
    op_req.request <= 1'b0;
    @(negedge hclk);
    chk(32'(op_resp.accepted), 32'h1);
    for (int i = 0; i < 1000; i++) begin
      if (op_resp.done === 1'b1) break;
      if (tick === 1'b1) n++;
      @(negedge hclk);
    end
    chk(n, 3);
    @(posedge hclk);
  endtask
  task t_gate(input logic locked);
    mem(1'b0, 1'b0, 1'b1);
    chk({mr.blocked, mr.rdata}, locked ? 9'h100 : 9'h05a);
    mem(1'b0, 1'b1, 1'b0);
    chk({mr.blocked, mr.rdata}, 9'h05a);
    mem(1'b1, 1'b1, 1'b1);
    chk({mr.blocked, mr.write_enable}, locked ? 2'b10 : 2'b01);
  endtask
  task t_unlock(input logic d, input logic [63:0] k, input logic ok);
    sec <= !d;
    dbg <= d;
    bus(1'b1, ADDR_KEY_CTRL, 8'h01);
    for (int i = 0; i < 8; i++) bus(1'b1, ADDR_KEY_DATA, k[8*i+:8]);
    bus(1'b1, ADDR_KEY_CTRL, 8'h00);
    sec <= 1'b1;
    dbg <= 1'b0;
    bus(1'b0, ADDR_OPTION, 8'h00);
    chk({rd[1:0], unsec}, ok ? 3'b101 : 3'b110);
  endtask
  // main sequence
  initial begin
    do_reset(8'h83);
    t_options;
    t_ratio(8'h4f, 128);
    t_op;
    t_gate(1'b1);
    t_unlock(1'b1, KEY, 1'b0);
    t_unlock(1'b0, ~KEY, 1'b0);
    t_unlock(1'b0, KEY, 1'b1);
    t_gate(1'b0);
    do_reset(8'h63);
    t_options;
    t_ratio(8'h03, 4);
    t_unlock(1'b0, KEY, 1'b0);
    blank <= 1'b1;
    @(posedge hclk);
    blank <= 1'b0;
    repeat (2) @(posedge hclk);
    chk(32'(unsec), 32'h1);
    test_done;
  end
endmodule
